// [rtl/csbu_defines.vh]
// Offsets, field positions, encodings and reset values of the compare/skip/branch unit
`ifndef CSBU_DEFINES_VH
`define CSBU_DEFINES_VH
`define CSBU_OFF_CTRL    8'h00
`define CSBU_OFF_OPA     8'h04
`define CSBU_OFF_OPB     8'h08
`define CSBU_OFF_OFFSET  8'h0C
`define CSBU_OFF_PC      8'h10
`define CSBU_OFF_STATUS  8'h14
`define CSBU_OFF_RESULT  8'h18
`define CSBU_OFF_IOIN    8'h1C
`define CSBU_CTRL_OP_LSB   0
`define CSBU_CTRL_OP_MSB   3
`define CSBU_CTRL_SEL_LSB  4
`define CSBU_CTRL_SEL_MSB  6
`define CSBU_CTRL_TWO_WORD 7
`define CSBU_OP_CMP_SKIP_EQ 4'h0
`define CSBU_OP_CMP_REGS    4'h1
`define CSBU_OP_CMP_CARRY   4'h2
`define CSBU_OP_CMP_IMM     4'h3
`define CSBU_OP_SGC      4'h4
`define CSBU_OP_SGS      4'h5
`define CSBU_OP_SIC      4'h6
`define CSBU_OP_SIS      4'h7
`define CSBU_OP_BFS      4'h8
`define CSBU_OP_BFC      4'h9
`define CSBU_OP_BCC      4'hA
`define CSBU_FLAG_C      0
`define CSBU_FLAG_Z      1
`define CSBU_FLAG_N      2
`define CSBU_FLAG_V      3
`define CSBU_FLAG_S      4
`define CSBU_FLAG_H      5
`define CSBU_FLAG_MASK   8'h3F
`define CSBU_PC_RESET    16'h0000
`define CSBU_STATUS_RESET 8'h00
`define CSBU_GPR_BASE_CYC 3'h1
`define CSBU_IO_BASE_CYC  3'h2
`define CSBU_BR_BASE_CYC  3'h1
`define CSBU_CMP_CYC      3'h1
`endif

// [rtl/csbu_cmp_alu.v]
// Compare subtractor producing the six arithmetic flags
`timescale 1ns/1ps
`include "csbu_defines.vh"
module csbu_cmp_alu (
    input  wire [7:0] op_a,
    input  wire [7:0] op_b,
    input  wire       carry_in,
    input  wire       with_carry,
    input  wire       zero_in,
    output wire [5:0] flags
);
    wire       cin;
    wire [8:0] diff;
    wire [7:0] r;
    wire       fc;
    wire       fz;
    wire       fn;
    wire       fv;
    wire       fh;
    assign cin  = with_carry & carry_in;
    assign diff = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
    assign r    = diff[7:0];
    assign fc   = (~op_a[7] & op_b[7]) | (op_b[7] & r[7]) | (r[7] & ~op_a[7]);
    assign fh   = (~op_a[3] & op_b[3]) | (op_b[3] & r[3]) | (r[3] & ~op_a[3]);
    assign fn   = r[7];
    assign fv   = (op_a[7] & ~op_b[7] & ~r[7]) | (~op_a[7] & op_b[7] & r[7]);
    // Carry form keeps zero only if the earlier byte was zero too
    assign fz   = (r == 8'h00) & (~with_carry | zero_in);
    assign flags = {fh, fn ^ fv, fv, fn, fz, fc};
endmodule // csbu_cmp_alu

// [rtl/csbu_core.v]
// Compare, skip and branch execution unit with an AHB-Lite register slave
`timescale 1ns/1ps
`include "csbu_defines.vh"
module csbu_core (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    input  wire [7:0]  io_pins,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         busy,
    output reg         taken
);
    reg  [7:0]  io_meta_reg;
    reg  [7:0]  io_sync_reg;
    reg  [7:0]  opa_reg;
    reg  [7:0]  opb_reg;
    reg  [7:0]  offset_reg;
    reg  [15:0] pc_reg;
    reg  [7:0]  status_reg;
    reg  [7:0]  ctrl_reg;
    reg  [2:0]  cycles_reg;
    reg  [2:0]  cnt_reg;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg  [31:0] rd_next;
    reg         cond;
    reg  [2:0]  cyc_next;
    reg  [15:0] pc_next;
    reg  [7:0]  status_next;
    reg         is_cmp;
    wire        addr_phase;
    wire [3:0]  op;
    wire [2:0]  sel;
    wire        two_word;
    wire [5:0]  cmp_flags;
    wire        start;
    wire [15:0] k_ext;
    wire        is_skip;
    wire        is_io_skip;
    wire        is_branch;
    wire [2:0]  base_cyc;
    wire [2:0]  skip_extra;

    assign addr_phase = hsel & htrans[1] & hready;
    assign op         = hwdata[`CSBU_CTRL_OP_MSB:`CSBU_CTRL_OP_LSB];
    assign sel        = hwdata[`CSBU_CTRL_SEL_MSB:`CSBU_CTRL_SEL_LSB];
    assign two_word   = hwdata[`CSBU_CTRL_TWO_WORD];
    // Launch is ignored while a previous instruction still counts cycles
    assign start      = wr_pend_reg & (wr_addr_reg == `CSBU_OFF_CTRL) & ~busy;
    assign k_ext      = {{9{offset_reg[6]}}, offset_reg[6:0]};
    // Op classes; codes outside the table act as a one-cycle no-op
    assign is_skip    = (op == `CSBU_OP_CMP_SKIP_EQ) | ((op >= `CSBU_OP_SGC) & (op <= `CSBU_OP_SIS));
    assign is_io_skip = (op == `CSBU_OP_SIC) | (op == `CSBU_OP_SIS);
    assign is_branch  = (op >= `CSBU_OP_BFS) & (op <= `CSBU_OP_BCC);
    assign base_cyc   = is_io_skip ? `CSBU_IO_BASE_CYC : `CSBU_GPR_BASE_CYC;
    assign skip_extra = two_word ? 3'h2 : 3'h1;

    csbu_cmp_alu u_alu (
        .op_a       (opa_reg),
        .op_b       (opb_reg),
        .carry_in   (status_reg[`CSBU_FLAG_C]),
        .with_carry (op == `CSBU_OP_CMP_CARRY),
        .zero_in    (status_reg[`CSBU_FLAG_Z]),
        .flags      (cmp_flags)
    );

    // Pin bits cross into the core clock
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_meta_reg <= 8'h00;
            io_sync_reg <= 8'h00;
        end else begin
            io_meta_reg <= io_pins;
            io_sync_reg <= io_meta_reg;
        end
    end

    always @* begin
        cond        = 1'b0;
        is_cmp      = 1'b0;
        status_next = status_reg;
        cyc_next    = `CSBU_CMP_CYC;
        pc_next     = pc_reg + 16'h0001;
        case (op)
            `CSBU_OP_CMP_SKIP_EQ: cond = (opa_reg == opb_reg);
            `CSBU_OP_CMP_REGS, `CSBU_OP_CMP_CARRY, `CSBU_OP_CMP_IMM: begin
                is_cmp      = 1'b1;
                status_next = (status_reg & ~`CSBU_FLAG_MASK) | {2'b00, cmp_flags};
            end
            `CSBU_OP_SGC: cond = ~opa_reg[sel];
            `CSBU_OP_SGS: cond = opa_reg[sel];
            `CSBU_OP_SIC: cond = ~io_sync_reg[sel];
            `CSBU_OP_SIS: cond = io_sync_reg[sel];
            `CSBU_OP_BFS: cond = status_reg[sel];
            `CSBU_OP_BFC: cond = ~status_reg[sel];
            `CSBU_OP_BCC: cond = ~status_reg[`CSBU_FLAG_C];
            default: is_cmp = 1'b1;
        endcase
        if (is_skip) begin
            cyc_next = cond ? base_cyc + skip_extra : base_cyc;
            if (cond) begin
                pc_next = pc_reg + 16'h0001 + {13'h0, skip_extra};
            end
        end else if (is_branch) begin
            cyc_next = `CSBU_BR_BASE_CYC + {2'b00, cond};
            if (cond) begin
                pc_next = pc_reg + k_ext + 16'h0001;
            end
        end
    end

    always @* begin
        case (haddr)
            `CSBU_OFF_CTRL:   rd_next = {24'h000000, ctrl_reg};
            `CSBU_OFF_OPA:    rd_next = {24'h000000, opa_reg};
            `CSBU_OFF_OPB:    rd_next = {24'h000000, opb_reg};
            `CSBU_OFF_OFFSET: rd_next = {24'h000000, offset_reg};
            `CSBU_OFF_PC:     rd_next = {16'h0000, pc_reg};
            `CSBU_OFF_STATUS: rd_next = {24'h000000, status_reg};
            `CSBU_OFF_RESULT: rd_next = {27'h0000000, cycles_reg, taken, busy};
            `CSBU_OFF_IOIN:   rd_next = {24'h000000, io_sync_reg};
            default:          rd_next = 32'h00000000;
        endcase
    end

    // Bus side: zero wait state, always OKAY; unmapped reads give zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr;
            if (addr_phase && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

    // Operands may change while busy; the result is already latched
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opa_reg    <= 8'h00;
            opb_reg    <= 8'h00;
            offset_reg <= 8'h00;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                `CSBU_OFF_OPA:    opa_reg    <= hwdata[7:0];
                `CSBU_OFF_OPB:    opb_reg    <= hwdata[7:0];
                `CSBU_OFF_OFFSET: offset_reg <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 3'h0;
            busy    <= 1'b0;
        end else if (start) begin
            cnt_reg <= cyc_next - 3'h1;
            busy    <= 1'b1;
        end else if (busy) begin
            if (cnt_reg == 3'h0) begin
                busy <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end

    // Pc and status writes are refused while an instruction counts
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg   <= 8'h00;
            pc_reg     <= `CSBU_PC_RESET;
            status_reg <= `CSBU_STATUS_RESET;
            cycles_reg <= 3'h0;
            taken      <= 1'b0;
        end else if (start) begin
            // flags and pc land at launch
            ctrl_reg   <= hwdata[7:0];
            pc_reg     <= pc_next;
            status_reg <= status_next;
            cycles_reg <= cyc_next;
            taken      <= cond & ~is_cmp;
        end else if (wr_pend_reg && !busy) begin
            case (wr_addr_reg)
                `CSBU_OFF_PC:     pc_reg     <= hwdata[15:0];
                `CSBU_OFF_STATUS: status_reg <= hwdata[7:0];
                default: ;
            endcase
        end
    end
endmodule // csbu_core

// [dv/csbu_core_properties.sv]
// Port assertions for the compare/skip/branch unit
`timescale 1ns/1ps
`include "csbu_defines.vh"
module csbu_props (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [7:0]  io_pins,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        busy,
    input wire        taken
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire      acc = hsel && htrans[1] && hready;
    wire      launch = wr_q && !busy;
    wire [3:0] launch_op = hwdata[`CSBU_CTRL_OP_MSB:`CSBU_CTRL_OP_LSB];
    reg       wr_q;
    reg [2:0] bcnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            bcnt <= 3'h0;
        end else begin
            wr_q <= acc && hwrite && haddr == `CSBU_OFF_CTRL;
            // Saturate so a stuck busy is not hidden by wrap
            bcnt <= !busy ? 3'h0 : (bcnt == 3'h7 ? bcnt : bcnt + 3'h1);
        end
    end
    ready_high_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not OKAY");
    busy_bound_a: assert property (bcnt <= 3'h4) else $error("busy too long");
    busy_cause_a: assert property ($rose(busy) |-> $past(wr_q)) else $error("busy without launch");
    taken_cause_a: assert property ($changed(taken) |-> $rose(busy)) else $error("taken moved alone");
    unmapped_zero_a: assert property (acc && !hwrite && haddr >= 8'h20 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    result_upper_a: assert property (acc && !hwrite && haddr == `CSBU_OFF_RESULT |=> hrdata[31:5] == 27'h0)
        else $error("result upper bits set");
    ioin_upper_a: assert property (acc && !hwrite && haddr == `CSBU_OFF_IOIN |=> hrdata[31:8] == 24'h0)
        else $error("io upper bits set");
    cmp_one_cycle_a: assert property (
        launch && launch_op inside {`CSBU_OP_CMP_REGS, `CSBU_OP_CMP_CARRY, `CSBU_OP_CMP_IMM}
        |=> busy ##1 (!busy && !taken)) else $error("compare not one cycle");
    gpr_skip_len_a: assert property (
        launch && launch_op inside {`CSBU_OP_CMP_SKIP_EQ, `CSBU_OP_SGC, `CSBU_OP_SGS}
        |=> busy ##1 (busy == taken)) else $error("register skip length wrong");
    io_skip_len_a: assert property (
        launch && launch_op inside {`CSBU_OP_SIC, `CSBU_OP_SIS}
        |=> busy [*2] ##1 (busy == taken)) else $error("io skip length wrong");
    branch_len_a: assert property (
        launch && launch_op inside {`CSBU_OP_BFS, `CSBU_OP_BFC, `CSBU_OP_BCC}
        |=> busy ##1 (busy == taken) ##1 !busy) else $error("branch length wrong");
endmodule // csbu_props
bind csbu_core csbu_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .io_pins(io_pins), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .busy(busy), .taken(taken));

// [dv/tb_top.sv]
// Self-checking bench for the compare/skip/branch unit
`timescale 1ns/1ps
`include "csbu_defines.vh"
module tb_top;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  opa;
        logic [7:0]  opb;
        logic [7:0]  st;
        logic [15:0] epc;
        logic [7:0]  est;
        logic [4:0]  eres;
    } csbu_row_t;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  io_pins = 8'h00;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        busy;
    logic        taken;
    logic [31:0] q;
    int          err_total = 0;
    int          checks_done = 0;
    // PC starts at 0100 in every row; opa also drives the I/O pins
    csbu_row_t   rows [12] = '{
        '{8'h01, 8'h10, 8'h20, 8'hC0, 16'h0101, 8'hD5, 5'h04}, '{8'h02, 8'h05, 8'h04, 8'h03, 16'h0101, 8'h02, 5'h04},
        '{8'h03, 8'h80, 8'h01, 8'h00, 16'h0101, 8'h38, 5'h04}, '{8'h80, 8'h5A, 8'h5A, 8'h2A, 16'h0103, 8'h2A, 5'h0E},
        '{8'h34, 8'hF7, 8'h00, 8'h00, 16'h0102, 8'h00, 5'h0A}, '{8'hF5, 8'h80, 8'h00, 8'h00, 16'h0103, 8'h00, 5'h0E},
        '{8'h06, 8'h01, 8'h00, 8'h00, 16'h0101, 8'h00, 5'h08}, '{8'h07, 8'h01, 8'h00, 8'h00, 16'h0102, 8'h00, 5'h0E},
        '{8'h18, 8'h00, 8'h7E, 8'h02, 16'h00FF, 8'h02, 5'h0A}, '{8'h09, 8'h00, 8'h40, 8'h00, 16'h00C1, 8'h00, 5'h0A},
        '{8'h0A, 8'h00, 8'h3F, 8'h00, 16'h0140, 8'h00, 5'h0A}, '{8'h0A, 8'h80, 8'h3F, 8'h01, 16'h0101, 8'h01, 5'h04}};
    csbu_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .io_pins(io_pins), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .busy(busy), .taken(taken));
    initial forever #12.5 hclk = ~hclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Idle edge first: a read right after launch still sees busy, even for a one-cycle op
    task automatic wait_done;
        @(posedge hclk);
        do bus(1'b0, `CSBU_OFF_RESULT, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic run(input csbu_row_t r);
        io_pins <= r.opa;
        bus(1'b1, `CSBU_OFF_OPA, {24'h0, r.opa});
        bus(1'b1, `CSBU_OFF_OPB, {24'h0, r.opb});
        bus(1'b1, `CSBU_OFF_OFFSET, {24'h0, r.opb});
        bus(1'b1, `CSBU_OFF_STATUS, {24'h0, r.st});
        bus(1'b1, `CSBU_OFF_PC, 32'h0100);
        bus(1'b1, `CSBU_OFF_CTRL, {24'h0, r.ctrl});
        wait_done;
        chk(q, {27'h0, r.eres});
        chk({31'h0, taken}, {31'h0, r.eres[1]});
        chk({31'h0, hresp}, 32'h0);
        bus(1'b0, `CSBU_OFF_PC, 32'h0);
        chk(q, {16'h0, r.epc});
        bus(1'b0, `CSBU_OFF_STATUS, 32'h0);
        chk(q, {24'h0, r.est});
    endtask
    task final_report;
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) run(rows[i]);
        // Longest skip, with a PC write dropped while busy
        bus(1'b1, `CSBU_OFF_CTRL, 32'hF7);
        bus(1'b1, `CSBU_OFF_PC, 32'h1234);
        wait_done;
        chk(q, 32'h12);
        bus(1'b0, `CSBU_OFF_PC, 32'h0);
        chk(q, 32'h0104);
        bus(1'b1, 8'h20, 32'hFFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `CSBU_OFF_IOIN, 32'h0);
        bus(1'b0, `CSBU_OFF_IOIN, 32'h0);
        chk(q, 32'h80);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({30'h0, busy, taken}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `CSBU_OFF_PC, 32'h0);
        chk(q, {16'h0, `CSBU_PC_RESET});
        bus(1'b0, `CSBU_OFF_STATUS, 32'h0);
        chk(q, {24'h0, `CSBU_STATUS_RESET});
        final_report;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        err_total++;
        final_report;
    end
endmodule // tb_top
